// ---- verilog/dso_defines.svh ----
`ifndef DSO_DEFINES_SVH
`define DSO_DEFINES_SVH

// register byte addresses
`define DSO_ADR_SRC_SEL0    8'h00
`define DSO_ADR_SRC_SEL1    8'h04
`define DSO_ADR_FAIL_MASK   8'h08
`define DSO_ADR_POLARITY    8'h0c
`define DSO_ADR_GEN_DELAY   8'h10
`define DSO_ADR_FAIL_DELAY  8'h14
`define DSO_ADR_TIMER_DELAY 8'h18
`define DSO_ADR_ZERO_SPEED  8'h1c
`define DSO_ADR_TORQUE      8'h20
`define DSO_ADR_STATUS      8'h24

// source item codes
`define DSO_ITEM_NONE       6'h00
`define DSO_ITEM_OVERVOLT   6'h0a
`define DSO_ITEM_UNDERVOLT  6'h0b
`define DSO_ITEM_OVERHEAT   6'h0c
`define DSO_ITEM_CMD_LOST   6'h0d
`define DSO_ITEM_RUN        6'h0e
`define DSO_ITEM_STOP       6'h0f
`define DSO_ITEM_STEADY     6'h10
`define DSO_ITEM_SPD_SEARCH 6'h13
`define DSO_ITEM_STEP_PULSE 6'h14
`define DSO_ITEM_SEQ_PULSE  6'h15
`define DSO_ITEM_READY      6'h16
`define DSO_ITEM_TRV_ACCEL  6'h17
`define DSO_ITEM_TRV_DECEL  6'h18
`define DSO_ITEM_ZERO_SPEED 6'h1a
`define DSO_ITEM_TORQUE_LOW 6'h1b
`define DSO_ITEM_TIMER_OUT  6'h1c
`define DSO_ITEM_FAILURE    6'h1d
`define DSO_ITEM_ENC_TUNE   6'h20
`define DSO_ITEM_ENC_DIR    6'h21
`define DSO_ITEM_ENERGY_BUF 6'h24
`define DSO_ITEM_FIRE_MODE  6'h25

// reset values
`define DSO_RST_SRC_RELAY1  6'h1d
`define DSO_RST_SRC_RELAY2  6'h0e
`define DSO_RST_SRC_OC      6'h01
`define DSO_RST_SRC_EXT     6'h00
`define DSO_RST_FAIL_MASK   3'h2
`define DSO_RST_POLARITY    6'h00
`define DSO_RST_DELAY       16'h0000
`define DSO_RST_ZSPD_FREQ   16'h00c8
`define DSO_RST_ZSPD_BAND   16'h0064
`define DSO_RST_TORQUE_LVL  16'h03e8
`define DSO_RST_TORQUE_BAND 16'h0032

// field positions
`define DSO_MASK_UNDERVOLT  0
`define DSO_MASK_OTHER      1
`define DSO_MASK_RESTART    2

// timing
`define DSO_CLK_HZ          32'h02625a00
`define DSO_TICK_MS         32'h0000000a
`define DSO_PULSE_TICKS     32'h0000000a

`endif

// ---- verilog/dso_pkg.sv ----
package dso_pkg;

    typedef struct packed {
        logic run_cmd;
        logic volt_out;
        logic dc_braking;
        logic accelerating;
        logic decelerating;
        logic dc_over;
        logic dc_under;
        logic fan_overheat;
        logic cmd_lost;
        logic speed_search;
        logic step_advance;
        logic seq_cycle;
        logic healthy;
        logic traverse_mode;
        logic traverse_accel_reached;
        logic traverse_decel_reached;
        logic vector_mode;
        logic sensorless_mode;
        logic autotune;
        logic enc_present;
        logic enc_feedback;
        logic enc_dir_fault;
        logic energy_buffering;
        logic fire_mode_cfg;
        logic fire_mode_active;
        logic trip_undervolt;
        logic trip_other;
        logic trip_restart_final;
    } dso_drv_status_t;

    typedef struct packed {
        logic [15:0] off;
        logic [15:0] on;
    } dso_delay_t;

    typedef struct packed {
        logic        level;
        logic [15:0] cnt;
    } dso_flt_state_t;

    typedef struct packed {
        logic             ack;
        logic [31:0]      rdata;
        logic [5:0][5:0]  src;
        logic [2:0]       fail_mask;
        logic [5:0]       polarity;
        dso_delay_t       gen_dly;
        dso_delay_t       fail_dly;
        dso_delay_t       timer_dly;
        logic [31:0]      zspd;
        logic [31:0]      torq;
        logic [19:0]      tick_cnt;
        logic             tick;
        logic             zero_speed;
        logic             torque_low;
        logic [7:0]       step_cnt;
        logic [7:0]       seq_cnt;
        logic             timer_s1;
        logic             timer_s2;
        logic [5:0]       contacts;
    } dso_sel_state_t;

endpackage

// ---- verilog/dso_delay_filter.sv ----
`timescale 1ns/10ps
`include "dso_defines.svh"
module dso_delay_filter
    import dso_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       tick_in,
    input  wire logic       cond_in,
    input  wire dso_delay_t delay_in,
    output logic            level_out
);

    dso_flt_state_t st_reg;
    dso_flt_state_t st_next;
    logic [15:0]    lim;

    always_comb begin
        st_next = st_reg;
        lim     = st_reg.level ? delay_in.off : delay_in.on;
        // [R23] glitch restarts count
        if (cond_in == st_reg.level) begin
            st_next.cnt = 16'h0000;
        end else if (lim == 16'h0000) begin
            st_next.level = cond_in;
            st_next.cnt   = 16'h0000;
        end else if (tick_in) begin
            if (st_reg.cnt >= lim - 16'h0001) begin
                st_next.level = cond_in;
                st_next.cnt   = 16'h0000;
            end else begin
                st_next.cnt = st_reg.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;

endmodule

// ---- verilog/dso_output_selector.sv ----
`timescale 1ns/10ps
`include "dso_defines.svh"
// Operation
// [R01] item 10 asserts while bus voltage is above overvoltage threshold
// [R02] item 11 asserts while bus voltage is below undervoltage level
// [R03] item 12 asserts while cooling fan overheat is present
// [R04] item 13 asserts on loss of analog or serial command, options included
// [R05] item 14 asserts while running with output voltage, not in DC braking
// [R06] item 15 asserts only with run command off and no output voltage
// [R07] item 16 asserts only at constant speed
// [R08] item 19 asserts while speed search runs
// [R09] items 20 and 21 pulse on step advance and sequence cycle
// [R10] item 22 asserts when healthy, idle and awaiting run command
// [R11] items 23 and 24 signal traverse accel and decel frequency reached
// [R12] item 26 flags zero speed in vector mode with frequency and band
// [R13] item 27 flags low torque in sensorless or vector mode with band
// [R14] item 28 follows timer terminal with its own on and off delays
// [R15] item 32 warns in autotune without encoder board or feedback mode
// [R16] item 33 warns in autotune on encoder wiring or direction fault
// [R17] item 36 asserts while energy buffering runs after power loss
// [R18] item 37 asserts during fire mode when fire mode is enabled
// [R19] failure output gated by three-bit type mask, default 010
// [R20] failure output uses its own on-delay and off-delay
// [R21] general delays apply to every output and every other source
// [R22] per-output polarity bit, 0 normally open, 1 normally closed
// [R23] delay timers count a fixed time base and restart on glitches
module dso_output_selector
    import dso_pkg::*;
#(
    parameter int TICK_CYCLES = (`DSO_CLK_HZ / 32'h000003e8) * `DSO_TICK_MS,
    parameter int PULSE_TICKS = `DSO_PULSE_TICKS
) (
    input  wire logic            mclk_in,
    input  wire logic            rst_n_in,
    input  wire logic            wb_cyc_in,
    input  wire logic            wb_stb_in,
    input  wire logic            wb_we_in,
    input  wire logic [7:0]      wb_adr_in,
    input  wire logic [3:0]      wb_sel_in,
    input  wire logic [31:0]     wb_dat_in,
    output logic      [31:0]     wb_dat_out,
    output logic                 wb_ack_out,
    input  wire dso_drv_status_t status_in,
    input  wire logic [15:0]     speed_in,
    input  wire logic [15:0]     torque_in,
    input  wire logic            timer_pin_in,
    output logic      [4:0]      relay_out,
    output logic                 open_collector_output_out
);

    localparam int NUM_OUT = 6;

    logic [1:0]     rst_sync_reg;
    logic           rst_n;
    dso_sel_state_t st_reg;
    dso_sel_state_t st_next;
    logic [63:0]    cond;
    logic [5:0]     filt;
    logic           timer_level;
    logic           fail_cond;
    logic [31:0]    rd_word;
    logic [31:0]    sel0_word;
    logic [31:0]    sel1_word;
    logic [31:0]    wr_word;
    logic [7:0]     adr;
    logic           access;

    // byte lane merge for register writes
    function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // hysteresis around lvl with width band; prev keeps the state inside the band
    function automatic logic hyst_below(input logic [15:0] val,
                                        input logic [15:0] lvl,
                                        input logic [15:0] band,
                                        input logic        prev);
        logic [16:0] lo;
        logic [16:0] hi;
        logic [16:0] half;
        half = {2'b00, band[15:1]};
        lo   = ({1'b0, lvl} > half) ? ({1'b0, lvl} - half) : 17'h00000;
        hi   = {1'b0, lvl} + half;
        if (prev) begin
            return {1'b0, val} <= hi;
        end
        return {1'b0, val} < lo;
    endfunction

    // reset release through two flops
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // [R19] failure type mask
    assign fail_cond = (st_reg.fail_mask[`DSO_MASK_UNDERVOLT] & status_in.trip_undervolt)
                     | (st_reg.fail_mask[`DSO_MASK_OTHER]     & status_in.trip_other)
                     | (st_reg.fail_mask[`DSO_MASK_RESTART]   & status_in.trip_restart_final);

    always_comb begin
        cond = 64'h0000000000000000;
        // [R01] overvoltage
        cond[`DSO_ITEM_OVERVOLT]   = status_in.dc_over;
        // [R02] undervoltage
        cond[`DSO_ITEM_UNDERVOLT]  = status_in.dc_under;
        // [R03] fan overheat
        cond[`DSO_ITEM_OVERHEAT]   = status_in.fan_overheat;
        // [R04] command loss
        cond[`DSO_ITEM_CMD_LOST]   = status_in.cmd_lost;
        // [R05] running, braking excluded
        cond[`DSO_ITEM_RUN]        = status_in.run_cmd & status_in.volt_out & ~status_in.dc_braking;
        // [R06] stopped
        cond[`DSO_ITEM_STOP]       = ~status_in.run_cmd & ~status_in.volt_out;
        // [R07] constant speed
        cond[`DSO_ITEM_STEADY]     = status_in.volt_out & ~status_in.accelerating & ~status_in.decelerating;
        // [R08] speed search
        cond[`DSO_ITEM_SPD_SEARCH] = status_in.speed_search;
        // [R09] stretched sequence pulses
        cond[`DSO_ITEM_STEP_PULSE] = st_reg.step_cnt != 8'h00;
        cond[`DSO_ITEM_SEQ_PULSE]  = st_reg.seq_cnt != 8'h00;
        // [R10] ready and idle
        cond[`DSO_ITEM_READY]      = status_in.healthy & ~status_in.run_cmd & ~status_in.volt_out;
        // [R11] traverse levels
        cond[`DSO_ITEM_TRV_ACCEL]  = status_in.traverse_mode & status_in.traverse_accel_reached;
        cond[`DSO_ITEM_TRV_DECEL]  = status_in.traverse_mode & status_in.traverse_decel_reached;
        // [R12] zero speed, vector only
        cond[`DSO_ITEM_ZERO_SPEED] = status_in.vector_mode & st_reg.zero_speed;
        // [R13] low torque, sensorless or vector
        cond[`DSO_ITEM_TORQUE_LOW] = (status_in.vector_mode | status_in.sensorless_mode) & st_reg.torque_low;
        // [R14] delayed timer terminal
        cond[`DSO_ITEM_TIMER_OUT]  = timer_level;
        cond[`DSO_ITEM_FAILURE]    = fail_cond;
        // [R15] encoder absent or not feedback
        cond[`DSO_ITEM_ENC_TUNE]   = status_in.autotune & (~status_in.enc_present | ~status_in.enc_feedback);
        // [R16] encoder wiring fault
        cond[`DSO_ITEM_ENC_DIR]    = status_in.autotune & status_in.enc_present & status_in.enc_feedback
                                   & status_in.enc_dir_fault;
        // [R17] energy buffering
        cond[`DSO_ITEM_ENERGY_BUF] = status_in.energy_buffering;
        // [R18] fire mode
        cond[`DSO_ITEM_FIRE_MODE]  = status_in.fire_mode_cfg & status_in.fire_mode_active;
    end

    // [R14] timer terminal delay
    dso_delay_filter u_timer_filter (
        .clk_in    (mclk_in),
        .rst_n_in  (rst_n),
        .tick_in   (st_reg.tick),
        .cond_in   (st_reg.timer_s2),
        .delay_in  (st_reg.timer_dly),
        .level_out (timer_level)
    );

    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
        dso_delay_t dly;
        // [R20] failure source uses trip delays
        // [R21] all other sources use general delays
        assign dly = (st_reg.src[i] == `DSO_ITEM_FAILURE) ? st_reg.fail_dly : st_reg.gen_dly;
        dso_delay_filter u_filter (
            .clk_in    (mclk_in),
            .rst_n_in  (rst_n),
            .tick_in   (st_reg.tick),
            .cond_in   (cond[st_reg.src[i]]),
            .delay_in  (dly),
            .level_out (filt[i])
        );
    end

    assign sel0_word = {2'b00, st_reg.src[3], 2'b00, st_reg.src[2], 2'b00, st_reg.src[1], 2'b00, st_reg.src[0]};
    assign sel1_word = {16'h0000, 2'b00, st_reg.src[5], 2'b00, st_reg.src[4]};
    assign adr       = {wb_adr_in[7:2], 2'b00};
    assign access    = wb_cyc_in & wb_stb_in & ~st_reg.ack;

    always_comb begin
        case (adr)
            `DSO_ADR_SRC_SEL0: begin
                rd_word = sel0_word;
            end
            `DSO_ADR_SRC_SEL1: begin
                rd_word = sel1_word;
            end
            `DSO_ADR_FAIL_MASK: begin
                rd_word = {29'h00000000, st_reg.fail_mask};
            end
            `DSO_ADR_POLARITY: begin
                rd_word = {26'h0000000, st_reg.polarity};
            end
            `DSO_ADR_GEN_DELAY: begin
                rd_word = st_reg.gen_dly;
            end
            `DSO_ADR_FAIL_DELAY: begin
                rd_word = st_reg.fail_dly;
            end
            `DSO_ADR_TIMER_DELAY: begin
                rd_word = st_reg.timer_dly;
            end
            `DSO_ADR_ZERO_SPEED: begin
                rd_word = st_reg.zspd;
            end
            `DSO_ADR_TORQUE: begin
                rd_word = st_reg.torq;
            end
            `DSO_ADR_STATUS: begin
                rd_word = {18'h00000, filt, 2'b00, st_reg.contacts};
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    always_comb begin
        wr_word = apply_sel(rd_word, wb_dat_in, wb_sel_in);
    end

    always_comb begin
        st_next          = st_reg;
        st_next.ack      = 1'b0;
        st_next.timer_s1 = timer_pin_in;
        st_next.timer_s2 = st_reg.timer_s1;

        // [R23] fixed time base
        if (st_reg.tick_cnt == 20'(TICK_CYCLES - 1)) begin
            st_next.tick_cnt = 20'h00000;
            st_next.tick     = 1'b1;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt + 20'h00001;
            st_next.tick     = 1'b0;
        end

        // [R09] a new event reloads even while the count runs out
        if (status_in.step_advance) begin
            st_next.step_cnt = 8'(PULSE_TICKS);
        end else if (st_reg.tick && st_reg.step_cnt != 8'h00) begin
            st_next.step_cnt = st_reg.step_cnt - 8'h01;
        end
        if (status_in.seq_cycle) begin
            st_next.seq_cnt = 8'(PULSE_TICKS);
        end else if (st_reg.tick && st_reg.seq_cnt != 8'h00) begin
            st_next.seq_cnt = st_reg.seq_cnt - 8'h01;
        end

        // [R12] zero speed band
        st_next.zero_speed = hyst_below(speed_in, st_reg.zspd[15:0], st_reg.zspd[31:16], st_reg.zero_speed);
        // [R13] torque band
        st_next.torque_low = hyst_below(torque_in, st_reg.torq[15:0], st_reg.torq[31:16], st_reg.torque_low);

        if (access) begin
            st_next.ack   = 1'b1;
            st_next.rdata = rd_word;
            if (wb_we_in) begin
                case (adr)
                    `DSO_ADR_SRC_SEL0: begin
                        st_next.src[0] = wr_word[5:0];
                        st_next.src[1] = wr_word[13:8];
                        st_next.src[2] = wr_word[21:16];
                        st_next.src[3] = wr_word[29:24];
                    end
                    `DSO_ADR_SRC_SEL1: begin
                        st_next.src[4] = wr_word[5:0];
                        st_next.src[5] = wr_word[13:8];
                    end
                    `DSO_ADR_FAIL_MASK: begin
                        st_next.fail_mask = wr_word[2:0];
                    end
                    `DSO_ADR_POLARITY: begin
                        st_next.polarity = wr_word[5:0];
                    end
                    `DSO_ADR_GEN_DELAY: begin
                        st_next.gen_dly = wr_word;
                    end
                    `DSO_ADR_FAIL_DELAY: begin
                        st_next.fail_dly = wr_word;
                    end
                    `DSO_ADR_TIMER_DELAY: begin
                        st_next.timer_dly = wr_word;
                    end
                    `DSO_ADR_ZERO_SPEED: begin
                        st_next.zspd = wr_word;
                    end
                    `DSO_ADR_TORQUE: begin
                        st_next.torq = wr_word;
                    end
                    default: begin
                        st_next.ack = 1'b1;
                    end
                endcase
            end
        end

        // [R22] polarity applied after the delay
        st_next.contacts = filt ^ st_reg.polarity;
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_reg           <= '0;
            st_reg.src[0]    <= `DSO_RST_SRC_RELAY1;
            st_reg.src[1]    <= `DSO_RST_SRC_RELAY2;
            st_reg.src[2]    <= `DSO_RST_SRC_OC;
            st_reg.src[3]    <= `DSO_RST_SRC_EXT;
            st_reg.src[4]    <= `DSO_RST_SRC_EXT;
            st_reg.src[5]    <= `DSO_RST_SRC_EXT;
            st_reg.fail_mask <= `DSO_RST_FAIL_MASK;
            st_reg.polarity  <= `DSO_RST_POLARITY;
            st_reg.gen_dly   <= {`DSO_RST_DELAY, `DSO_RST_DELAY};
            st_reg.fail_dly  <= {`DSO_RST_DELAY, `DSO_RST_DELAY};
            st_reg.timer_dly <= {`DSO_RST_DELAY, `DSO_RST_DELAY};
            st_reg.zspd      <= {`DSO_RST_ZSPD_BAND, `DSO_RST_ZSPD_FREQ};
            st_reg.torq      <= {`DSO_RST_TORQUE_BAND, `DSO_RST_TORQUE_LVL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_ack_out                = st_reg.ack;
    assign wb_dat_out                = st_reg.rdata;
    // bit order: relay 1, relay 2, open collector, relays 3 to 5
    assign relay_out                 = {st_reg.contacts[5:3], st_reg.contacts[1:0]};
    assign open_collector_output_out = st_reg.contacts[2];

endmodule

// ---- tb/dso_output_selector_assertions.sv ----
`timescale 1ns/10ps
`include "dso_defines.svh"
module dso_output_selector_checker
    import dso_pkg::*;
(
    input wire logic            mclk_in,
    input wire logic            rst_n_in,
    input wire logic            wb_cyc_in,
    input wire logic            wb_stb_in,
    input wire logic            wb_we_in,
    input wire logic [7:0]      wb_adr_in,
    input wire logic [31:0]     wb_dat_in,
    input wire logic            wb_ack_out,
    input wire dso_drv_status_t status_in,
    input wire logic [4:0]      relay_out
);
    // {zero general delay, relay1 polarity, relay1 source}, mirrored from acked writes
    logic [7:0] cfg_reg;
    logic [7:0] cfg_q_reg;
    logic [5:0] src;
    logic       pl;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_reg <= 8'h9d;
            cfg_q_reg <= 8'h9d;
        end else begin
            cfg_q_reg <= cfg_reg;
            if (wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out) begin
                if (wb_adr_in == `DSO_ADR_SRC_SEL0) cfg_reg[5:0] <= wb_dat_in[5:0];
                if (wb_adr_in == `DSO_ADR_POLARITY) cfg_reg[6] <= wb_dat_in[0];
                if (wb_adr_in == `DSO_ADR_GEN_DELAY) cfg_reg[7] <= (wb_dat_in == 32'h0);
            end
        end
    end
    // judge only once the mirror has settled
    assign src = (cfg_reg == cfg_q_reg && cfg_reg[7]) ? cfg_reg[5:0] : 6'h3f;
    assign pl = cfg_reg[6];
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    property p_ack_answer;
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("bus answer missing or long");
    property p_ovr;
        src == 6'h0a |-> relay_out[0] == ($past(status_in.dc_over, 2) ^ pl);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overvoltage item wrong");
    property p_undr;
        src == 6'h0b |-> relay_out[0] == ($past(status_in.dc_under, 2) ^ pl);
    endproperty
    a_undr: assert property (p_undr) else $error("undervoltage item wrong");
    property p_heat;
        src == 6'h0c |-> relay_out[0] == ($past(status_in.fan_overheat, 2) ^ pl);
    endproperty
    a_heat: assert property (p_heat) else $error("overheat item wrong");
    property p_lost;
        src == 6'h0d |-> relay_out[0] == ($past(status_in.cmd_lost, 2) ^ pl);
    endproperty
    a_lost: assert property (p_lost) else $error("command loss item wrong");
    property p_run;
        src == 6'h0e |-> relay_out[0] == ($past(status_in.run_cmd & status_in.volt_out & ~status_in.dc_braking, 2) ^ pl);
    endproperty
    a_run: assert property (p_run) else $error("run item wrong");
    property p_stop;
        src == 6'h0f |-> relay_out[0] == ($past(~status_in.run_cmd & ~status_in.volt_out, 2) ^ pl);
    endproperty
    a_stop: assert property (p_stop) else $error("stop item wrong");
    property p_steady;
        src == 6'h10 |-> relay_out[0] == ($past(status_in.volt_out & ~status_in.accelerating
                                                & ~status_in.decelerating, 2) ^ pl);
    endproperty
    a_steady: assert property (p_steady) else $error("steady item wrong");
    property p_search;
        src == 6'h13 |-> relay_out[0] == ($past(status_in.speed_search, 2) ^ pl);
    endproperty
    a_search: assert property (p_search) else $error("speed search item wrong");
endmodule
bind dso_output_selector dso_output_selector_checker chk_u (.mclk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_ack_out, .status_in, .relay_out);

// ---- tb/dso_contactor_model.sv ----
`timescale 1ns/10ps
module dso_contactor_model (
    input  wire logic       clk_in,
    input  wire logic [5:0] coil_in,
    output logic      [5:0] closed_out
);
    // armature follows the coil one cycle late
    always_ff @(posedge clk_in) begin
        closed_out <= coil_in;
    end
endmodule

// ---- tb/dso_output_selector_test.sv ----
`timescale 1ns/10ps
`include "dso_defines.svh"
module dso_output_selector_test
    import dso_pkg::*;
;
    `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
        $display("BAD t=%0t got %h exp %h", $time, g, e); end end
    logic mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, pin = 1'b0, ack, oc;
    logic [7:0]      adr = 8'h00;
    logic [3:0]      sel = 4'h0;
    logic [31:0]     wdat = 32'h0, rdat, q;
    logic [15:0]     spd = 16'h0, trq = 16'h0;
    logic [4:0]      rly;
    logic [5:0]      closed;
    dso_drv_status_t st = '0;
    int              num_errors = 0, n_compared = 0;
    always #12.5 mclk = ~mclk;
    dso_output_selector #(.TICK_CYCLES(4), .PULSE_TICKS(2)) dut_u (.mclk_in(mclk), .rst_n_in(rst_n),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .status_in(st), .speed_in(spd), .torque_in(trq),
        .timer_pin_in(pin), .relay_out(rly), .open_collector_output_out(oc));
    dso_contactor_model plant_u (.clk_in(mclk), .coil_in({rly[4:2], oc, rly[1:0]}), .closed_out(closed));
    task give_verdict;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin
            num_errors++;
            give_verdict;
        end
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic drive(logic [27:0] v, int n);
        @(posedge mclk);
        st <= v;
        idle(n);
    endtask
    task automatic await(logic v);
        int n = 0;
        while (rly[0] !== v && n < 24) begin
            @(posedge mclk);
            n++;
        end
        `CHK(rly[0], v)
        if (rly[0] !== v) give_verdict;
    endtask
    // select a relay1 source, apply drive state and measurements, judge relay1
    task automatic sq(logic [5:0] c, logic [27:0] v, logic [15:0] s, logic [15:0] t, logic e);
        wb(1'b1, `DSO_ADR_SRC_SEL0, {26'h0, c});
        {spd, trq} <= {s, t};
        drive(v, 4);
        `CHK(rly[0], e)
    endtask
    task automatic t_reset;
        logic [31:0] ev [11] = '{32'h00010e1d, 0, 32'h2, 0, 0, 0, 0, 32'h006400c8, 32'h003203e8, 0, 0};
        for (int i = 0; i < 11; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0);
            `CHK(q, ev[i])
        end
        wb(1'b1, `DSO_ADR_STATUS, 32'hffffffff);
        wb(1'b0, `DSO_ADR_STATUS, 32'h0);
        `CHK(q, 32'h0)
    endtask
    task automatic t_items;
        logic [5:0] c [15] = '{6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h13, 6'h16, 6'h17, 6'h18,
                               6'h20, 6'h21, 6'h24, 6'h25};
        logic [27:0] on [15] = '{28'h400000, 28'h200000, 28'h100000, 28'h80000, 28'hc000000, 0, 28'h4000000,
                                 28'h40000, 28'h8000, 28'h6000, 28'h5000, 28'h200, 28'h3c0, 28'h20, 28'h18};
        logic [27:0] off [15] = '{0, 0, 0, 0, 28'he000000, 28'h8000000, 28'h5000000, 0, 28'h8008000, 28'h2000,
                                  28'h1000, 28'h380, 28'h1c0, 0, 28'h8};
        for (int i = 0; i < 15; i++) begin
            sq(c[i], on[i], 16'h0, 16'h1000, 1'b1);
            sq(c[i], off[i], 16'h0, 16'h1000, 1'b0);
        end
    endtask
    task automatic t_fail;
        wb(1'b1, `DSO_ADR_SRC_SEL0, 32'h1d);
        wb(1'b1, `DSO_ADR_FAIL_DELAY, 32'h00030002);
        drive(28'h4, 20);
        `CHK(rly[0], 1'b0)
        drive(28'h2, 2);
        drive(28'h0, 20);
        `CHK(rly[0], 1'b0)
        drive(28'h2, 4);
        `CHK(rly[0], 1'b0)
        await(1'b1);
        drive(28'h0, 6);
        `CHK(rly[0], 1'b1)
        await(1'b0);
        wb(1'b1, `DSO_ADR_FAIL_MASK, 32'h1);
        drive(28'h4, 1);
        await(1'b1);
        wb(1'b1, `DSO_ADR_FAIL_MASK, 32'h4);
        await(1'b0);
        drive(28'h1, 1);
        await(1'b1);
        drive(28'h0, 1);
        await(1'b0);
    endtask
    task automatic t_misc;
        wb(1'b1, `DSO_ADR_POLARITY, 32'h3f);
        idle(3);
        `CHK({rly[4:2], oc, rly[1:0]}, 6'h3f)
        wb(1'b1, `DSO_ADR_POLARITY, 32'h5);
        idle(3);
        `CHK({rly, oc, closed}, 12'h0c5)
        wb(1'b1, `DSO_ADR_POLARITY, 32'h0);
        sq(6'h1a, 28'h800, 16'h1000, 16'h0, 1'b0);
        sq(6'h1a, 28'h800, 16'h0, 16'h0, 1'b1);
        sq(6'h1b, 28'h400, 16'h0, 16'h1000, 1'b0);
        sq(6'h1b, 28'h400, 16'h0, 16'h0, 1'b1);
        sq(6'h14, 28'h0, 16'h0, 16'h0, 1'b0);
        drive(28'h20000, 0);
        drive(28'h0, 3);
        `CHK(rly[0], 1'b1)
        await(1'b0);
        sq(6'h15, 28'h10000, 16'h0, 16'h0, 1'b1);
        wb(1'b1, `DSO_ADR_TIMER_DELAY, 32'h00010001);
        wb(1'b1, `DSO_ADR_SRC_SEL0, 32'h1c);
        pin <= 1'b1;
        await(1'b1);
        pin <= 1'b0;
        await(1'b0);
        wb(1'b1, `DSO_ADR_GEN_DELAY, 32'h00010002);
        sq(6'h0a, 28'h400000, 16'h0, 16'h0, 1'b0);
        await(1'b1);
        drive(28'h0, 1);
        await(1'b0);
    endtask
    initial begin
        idle(5);
        rst_n <= 1'b1;
        idle(3);
        t_reset;
        t_items;
        t_fail;
        t_misc;
        give_verdict;
    end
endmodule
